// ---- sdwl_top.sv ----
`timescale 1ns/1ps
module sdwl_top
  import sdwl_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // serial link pins, write only
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdin,
  // converter controls
  output logic [5:0] output_code_bits,
  output logic [1:0] power_down_select_bits,
  output logic dac_enable,
  output logic pulldown_1k,
  output logic pulldown_100k,
  output logic pulldown_1m,
  output logic load_pulse
);
  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic cs_n_s; // synchronised select
  logic sclk_s; // synchronised link clock
  logic sdin_s; // synchronised data
  sdwl_sync u_cs (.clk(clk), .rstn(rstn), .d(cs_n), .reset_value(1'b1), .q(cs_n_s));
  sdwl_sync u_ck (.clk(clk), .rstn(rstn), .d(sclk), .reset_value(1'b1), .q(sclk_s));
  sdwl_sync u_dt (.clk(clk), .rstn(rstn), .d(sdin), .reset_value(1'b1), .q(sdin_s));

  ////////////////////////////////////////////////////////////////////////////
  // edge detection
  logic cs_n_d; // delayed select
  logic sclk_d; // delayed link clock
  logic sclk_seen; // select was low last cycle; masks the first link clock sample after select fell
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs_n_d <= 1'b1;
      sclk_d <= 1'b0;
    end else begin
      cs_n_d <= cs_n_s;
      sclk_d <= sclk_s;
    end
  end
  wire cs_fall = cs_n_d & ~cs_n_s;
  wire cs_rise = ~cs_n_d & cs_n_s;
  // with idle-high clock the level at select fall is not an edge
  wire sclk_rise = sclk_s & ~sclk_d & ~cs_n_s & sclk_seen;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sclk_seen <= 1'b0;
    end else begin
      sclk_seen <= ~cs_n_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // input shift register and bit counter
  logic [WORD_BITS-1:0] shift; // input word
  logic [4:0] count; // bits taken this frame
  wire [WORD_BITS-1:0] next_shift = {shift[WORD_BITS-2:0], sdin_s};
  wire count_full = (count == CNT_FULL);
  wire [4:0] next_count = count_full ? count : count + 5'h01;
  // shift on link rising edges, count restarts at select fall
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shift <= '0;
      count <= CNT_RESET;
    end else if (cs_fall) begin
      count <= CNT_RESET;
    end else if (sclk_rise) begin
      shift <= next_shift;
      count <= next_count;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // decode of the word
  // a short frame is corrupt and dropped; host resends
  wire word_ok = (count >= CNT_FULL);
  wire load = cs_rise & word_ok;
  wire [5:0] word_code = shift[CODE_MSB:CODE_LSB];
  wire [1:0] word_pd = shift[PD_MSB:PD_LSB];
  wire next_enable = (word_pd == sdwl_pd_normal);
  // code is forced to zero in power-down
  wire [5:0] next_code = next_enable ? word_code : CODE_RESET;

  ////////////////////////////////////////////////////////////////////////////
  // dac latch, all outputs registered
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      output_code_bits <= CODE_RESET;
      power_down_select_bits <= PD_RESET;
      dac_enable <= 1'b1;
      pulldown_1k <= 1'b0;
      pulldown_100k <= 1'b0;
      pulldown_1m <= 1'b0;
      load_pulse <= 1'b0;
    end else begin
      load_pulse <= load;
      if (load) begin
        output_code_bits <= next_code;
        power_down_select_bits <= word_pd;
        dac_enable <= next_enable;
        pulldown_1k <= (word_pd == sdwl_pd_1k);
        pulldown_100k <= (word_pd == sdwl_pd_100k);
        pulldown_1m <= (word_pd == sdwl_pd_1m);
      end
    end
  end
  // no output toward the host exists
endmodule

// ---- sdwl_pkg.sv ----
package sdwl_pkg;
  // word layout
  localparam int WORD_BITS = 16;
  localparam int CODE_MSB = 11;
  localparam int CODE_LSB = 6;
  localparam int CODE_BITS = 6;
  localparam int PD_MSB = 13;
  localparam int PD_LSB = 12;
  // reset values and the full frame bit count
  localparam logic [5:0] CODE_RESET = 6'h00;
  localparam logic [1:0] PD_RESET = 2'h0;
  localparam logic [4:0] CNT_RESET = 5'h00;
  localparam logic [4:0] CNT_FULL = 5'h10;
  // power-down selector values
  typedef enum logic [1:0] {
    sdwl_pd_normal = 2'h0,
    sdwl_pd_1k = 2'h1,
    sdwl_pd_100k = 2'h2,
    sdwl_pd_1m = 2'h3
  } sdwl_pd_e;
  // link timing
  localparam int CLK_PERIOD_PS = 5000;
  localparam int LINK_MIN_PERIOD_NS = 100;
  localparam int LINK_MIN_PERIOD_CYC = (LINK_MIN_PERIOD_NS * 1000) / CLK_PERIOD_PS;
endpackage

// ---- sdwl_sync.sv ----
`timescale 1ns/1ps
// two-stage synchroniser for one level
module sdwl_sync (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // level in and out
  input wire logic d,
  input wire logic reset_value,
  output logic q
);
  logic meta; // first stage, read only by q
  // two flops in series; reset loads 1 into both, reset_value is left unused
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      meta <= 1'b1;
      q <= 1'b1;
    end else begin
      meta <= d;
      q <= meta;
    end
  end
  logic unused_rv;
  assign unused_rv = reset_value;
endmodule

// ---- sdwl_chk.sv ----
`timescale 1ns/1ps
// checks on the latched converter controls
module sdwl_chk (
  // clock, reset and select pin
  input wire logic clk, rstn, cs_n,
  // latched controls
  input wire logic dac_enable, pulldown_1k, pulldown_100k, pulldown_1m, load_pulse,
  input wire logic [5:0] output_code_bits,
  input wire logic [1:0] power_down_select_bits
);
  wire logic [1:0] pdb = power_down_select_bits;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_pull_1k: assert property (pulldown_1k == (pdb == 2'h1))
    else $error("1k pull-down wrong");
  a_pull_100k: assert property (pulldown_100k == (pdb == 2'h2))
    else $error("100k pull-down wrong");
  a_pull_1m: assert property (pulldown_1m == (pdb == 2'h3))
    else $error("1M pull-down wrong");
  a_dac_on: assert property (dac_enable == (pdb == 2'h0))
    else $error("enable wrong for mode");
  a_down_zero: assert property (pdb != 2'h0 |-> output_code_bits == 6'h00)
    else $error("code not zero in power-down");
  a_load_flag: assert property ($changed({output_code_bits, pdb}) |-> load_pulse)
    else $error("latch moved without pulse");
  a_load_idle: assert property (load_pulse |-> cs_n && !$past(load_pulse))
    else $error("pulse while selected or doubled");
  a_one_pulse: assert property (load_pulse |=> !load_pulse [*8])
    else $error("pulse not single");
endmodule
bind sdwl_top sdwl_chk chk_u (.clk(clk), .rstn(rstn), .cs_n(cs_n), .dac_enable(dac_enable),
  .pulldown_1k(pulldown_1k), .pulldown_100k(pulldown_100k), .pulldown_1m(pulldown_1m),
  .load_pulse(load_pulse), .output_code_bits(output_code_bits),
  .power_down_select_bits(power_down_select_bits));

// ---- sdwl_host.sv ----
`timescale 1ns/1ps
// host side: write-only, drives select, clock, data
module sdwl_host (input wire logic clk, output logic cs_n, sclk, sdin);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    sdin = 1'b0;
  end
  // n bits msb first, clock idles at idle, 160 ns period
  task automatic send(input logic [15:0] w, input int n, input logic idle);
    int i;
    sclk <= idle;
    repeat (24) @(posedge clk);
    cs_n <= 1'b0;
    for (i = 15; i > 15 - n; i--) begin
      sclk <= 1'b0;
      sdin <= w[i];
      repeat (16) @(posedge clk);
      sclk <= 1'b1;
      repeat (16) @(posedge clk);
    end
    sclk <= idle;
    cs_n <= 1'b1;
    sdin <= ~sdin;
    repeat (24) @(posedge clk);
  endtask
endmodule

// ---- tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("BAD %s exp %h got %h", n, e, g); end end
module tb_top;
  import sdwl_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, en, p1, p2, p3, lp;
  logic [5:0] code;
  logic [1:0] pd;
  wire cs_n, sclk, sdin;
  int n_errors = 0, n_compared = 0, m;
  initial forever #2.5 clk = ~clk;
  sdwl_host host_u (.clk(clk), .cs_n(cs_n), .sclk(sclk), .sdin(sdin));
  sdwl_top dut_u (.clk(clk), .rstn(rstn), .cs_n(cs_n), .sclk(sclk), .sdin(sdin),
    .output_code_bits(code), .power_down_select_bits(pd), .dac_enable(en),
    .pulldown_1k(p1), .pulldown_100k(p2), .pulldown_1m(p3), .load_pulse(lp));
  task summarize;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watch for the load pulse while the frame runs; it comes before send returns
  task automatic load(input logic [15:0] w, input int n, input logic idle, input logic want);
    int k;
    logic seen;
    seen = 1'b0;
    fork
      host_u.send(w, n, idle);
      for (k = 0; k < 640; k++) begin
        @(posedge clk);
        if (lp === 1'b1) seen = 1'b1;
      end
    join
    `CHK("load", want, seen)
    if (want && !seen) summarize();
  endtask
  task automatic outs(input logic [1:0] p, input logic [5:0] c);
    `CHK("pd", p, pd)
    `CHK("code", (p == 2'h0) ? c : 6'h00, code)
    `CHK("pulls", {en, p3, p2, p1}, {p == 2'h0, p == 2'h3, p == 2'h2, p == 2'h1})
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    outs(2'h0, 6'h00);
    for (m = 0; m < 4; m++) begin
      load({2'h3, m[1:0], 6'h25 ^ {3{m[1:0]}}, 6'h15}, 16, m[0], 1'b1);
      outs(m[1:0], 6'h25 ^ {3{m[1:0]}});
    end
    $display("t_modes done");
    load({4'h0, 6'h3E, 6'h00}, 15, 1'b0, 1'b0);
    outs(2'h3, 6'h00);
    load({4'h0, 6'h3E, 6'h00}, 16, 1'b1, 1'b1);
    outs(2'h0, 6'h3E);
    $display("t_short done");
    rstn <= 1'b0;
    @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    outs(2'h0, 6'h00);
    $display("t_reset done");
    summarize();
  end
endmodule
